// file: sfsp_cfg.svh
// Summary of operation
// - read-status opcode: second byte returns primary status
// - third byte of read-status returns link status
// - clear-status opcode clears the program error bit and bit 3, not the erase error bit
// - busy pin falls when clear-status completes
// - 256 data bytes from fourth byte, ascending
// - page written automatically after data accepted
// - busy falls when ready for next page
// - program result recorded in primary status
// - bytes are eight bits, least significant first
// - sample on rising edge, shift on falling
// - program error flag set on failure, cleared
`ifndef SFSP_CFG_SVH
`define SFSP_CFG_SVH
`define SFSP_OP_READ_STATUS  8'h70
`define SFSP_OP_CLEAR_STATUS 8'h50
`define SFSP_OP_PAGE_PROGRAM 8'h41
`define SFSP_PAGE_BYTES      9'h100
`define SFSP_BIT_READY       7
`define SFSP_BIT_ERASE_ERR   5
`define SFSP_BIT_PROG_ERR    4
`define SFSP_BIT_ERR_LOW     3
`define SFSP_STATUS_RESET    8'h80
`define SFSP_LINK_RESET      8'h00
`endif

// file: sfsp_pkg.sv
package sfsp_pkg;
    // command sequencer states
    typedef enum logic [2:0] {
        SFSP_IDLE,
        SFSP_ST_PRIMARY,
        SFSP_ST_LINK,
        SFSP_ADDR_MID,
        SFSP_ADDR_HIGH,
        SFSP_DATA,
        SFSP_WRITE
    } sfsp_state_type;
endpackage

// file: sfsp_top.sv
`timescale 1ns/10ps
`include "sfsp_cfg.svh"
module sfsp_top
    import sfsp_pkg::*;
(
    input  wire logic        ref_clk,
    input  wire logic        rst_n,
    input  wire logic        serial_clock_in,     // transfer clock from programmer
    input  wire logic        serial_rx_line,      // data from programmer
    output logic             serial_tx_line,      // data to programmer
    output logic             handshake_pin,       // busy, high while active
    input  wire logic [7:0]  link_status,         // secondary status from handler
    output logic [7:0]       primary_status,      // status register contents
    output logic             rx_byte_valid,       // one-cycle strobe per byte received
    output logic [7:0]       rx_byte,             // last received byte
    output logic             flash_write_req,     // pulse: write buffered page
    output logic [23:0]      flash_addr,          // page base address
    output logic [7:0]       flash_wdata,         // data byte being streamed
    output logic             flash_wvalid,        // pulse per buffered byte
    input  wire logic        flash_done,          // pulse: page write ended
    input  wire logic        flash_error          // qualifies flash_done
);
    // three-stage synchronisers; stage one is read only by stage two
    logic [2:0]     clk_sync;
    logic [2:0]     rx_sync;
    logic           clk_rise;                     // sampled rising edge of transfer clock
    logic           clk_fall;                     // sampled falling edge
    logic           clk_level;                    // filtered transfer clock level
    logic [2:0]     bit_count;                    // bits gathered in this byte
    logic [7:0]     shift_in;                     // receive shifter
    logic [7:0]     shift_out;                    // transmit shifter
    logic           tx_load;                      // load a byte for sending
    logic [7:0]     tx_byte;                      // byte to be loaded
    sfsp_state_type state;
    logic [8:0]     data_count;                   // page bytes accepted
    logic [7:0]     page_mem [0:255];             // page buffer
    logic [8:0]     stream_idx;                   // write stream pointer
    logic           streaming;                    // page being handed to flash
    logic           page_last;                    // 256th page byte arrives this cycle

    // synchronise the outside pins
    always_ff @(posedge ref_clk) begin
        if (!rst_n) begin
            // both pins idle high; a zero here would fake an edge after reset
            clk_sync <= 3'h7;
            rx_sync  <= 3'h7;
        end else begin
            clk_sync <= {clk_sync[1:0], serial_clock_in};
            rx_sync  <= {rx_sync[1:0], serial_rx_line};
        end
    end

    // filtered level moves only when stages two and three agree
    always_ff @(posedge ref_clk) begin
        if (!rst_n) begin
            clk_level <= 1'b1;                    // programmer holds the clock high when idle
        end else if (clk_sync[1] == clk_sync[2]) begin
            clk_level <= clk_sync[2];
        end
    end

    // an edge counts once stages two and three agree on the new level
    assign clk_rise = clk_sync[1] & clk_sync[2] & ~clk_level;
    assign clk_fall = ~clk_sync[1] & ~clk_sync[2] & clk_level;

    // last byte of the page: starts the write and keeps busy up
    assign page_last = (state == SFSP_DATA) && rx_byte_valid &&
                       (data_count == `SFSP_PAGE_BYTES - 9'h001);

    // receive shifter, lsb arrives first
    always_ff @(posedge ref_clk) begin
        if (!rst_n) begin
            bit_count     <= 3'h0;
            shift_in      <= 8'h00;
            rx_byte       <= 8'h00;
            rx_byte_valid <= 1'b0;
        end else begin
            rx_byte_valid <= 1'b0;
            if (clk_rise) begin
                shift_in  <= {rx_sync[2], shift_in[7:1]};
                bit_count <= bit_count + 3'h1;
                if (bit_count == 3'h7) begin
                    // whole byte in; strobe it once
                    rx_byte       <= {rx_sync[2], shift_in[7:1]};
                    rx_byte_valid <= 1'b1;
                end
            end
        end
    end

    // transmit shifter, changes on falling edges, lsb first
    always_ff @(posedge ref_clk) begin
        if (!rst_n) begin
            shift_out      <= 8'h00;
            serial_tx_line <= 1'b1;
        end else if (tx_load) begin
            // load only; the line keeps its bit until the byte's first falling edge
            shift_out      <= tx_byte;
        end else if (clk_fall) begin
            // loads follow rising edges, so a load never hides a falling edge
            serial_tx_line <= shift_out[0];
            shift_out      <= {1'b1, shift_out[7:1]};
        end
    end

    // load status bytes as their slot begins
    always_comb begin
        tx_load = 1'b0;
        tx_byte = primary_status;
        if (rx_byte_valid && state == SFSP_IDLE && rx_byte == `SFSP_OP_READ_STATUS) begin
            tx_load = 1'b1;
            tx_byte = primary_status;
        end else if (state == SFSP_ST_PRIMARY && clk_rise && bit_count == 3'h7) begin
            // slot of second byte ends: queue the link status next
            tx_load = 1'b1;
            tx_byte = link_status;
        end
    end

    // command sequencer
    always_ff @(posedge ref_clk) begin
        if (!rst_n) begin
            state      <= SFSP_IDLE;
            data_count <= 9'h000;
            flash_addr <= 24'h000000;
        end else begin
            unique case (state)
                SFSP_IDLE: begin
                    if (rx_byte_valid) begin
                        if (rx_byte == `SFSP_OP_READ_STATUS) begin
                            state <= SFSP_ST_PRIMARY;
                        end else if (rx_byte == `SFSP_OP_PAGE_PROGRAM) begin
                            state <= SFSP_ADDR_MID;
                        end
                        // clear-status and unknown codes finish in place
                    end
                end
                SFSP_ST_PRIMARY: begin
                    if (rx_byte_valid) begin
                        state <= SFSP_ST_LINK;
                    end
                end
                SFSP_ST_LINK: begin
                    if (rx_byte_valid) begin
                        state <= SFSP_IDLE;
                    end
                end
                SFSP_ADDR_MID: begin
                    if (rx_byte_valid) begin
                        flash_addr <= {flash_addr[23:16], rx_byte, 8'h00};
                        state      <= SFSP_ADDR_HIGH;
                    end
                end
                SFSP_ADDR_HIGH: begin
                    if (rx_byte_valid) begin
                        flash_addr <= {rx_byte, flash_addr[15:8], 8'h00};
                        data_count <= 9'h000;
                        state      <= SFSP_DATA;
                    end
                end
                SFSP_DATA: begin
                    if (rx_byte_valid) begin
                        data_count <= data_count + 9'h001;
                        if (data_count == `SFSP_PAGE_BYTES - 9'h001) begin
                            state <= SFSP_WRITE;
                        end
                    end
                end
                SFSP_WRITE: begin
                    if (flash_done) begin
                        state <= SFSP_IDLE;
                    end
                end
            endcase
        end
    end

    // page buffer fills in ascending order
    always_ff @(posedge ref_clk) begin
        if (state == SFSP_DATA && rx_byte_valid) begin
            page_mem[data_count[7:0]] <= rx_byte;
        end
    end

    // hand the page to flash on our own, byte by byte, then request the write
    always_ff @(posedge ref_clk) begin
        if (!rst_n) begin
            streaming       <= 1'b0;
            stream_idx      <= 9'h000;
            flash_wvalid    <= 1'b0;
            flash_wdata     <= 8'h00;
            flash_write_req <= 1'b0;
        end else begin
            flash_wvalid    <= 1'b0;
            flash_write_req <= 1'b0;
            if (page_last) begin
                streaming  <= 1'b1;
                stream_idx <= 9'h000;
            end else if (streaming) begin
                if (stream_idx == `SFSP_PAGE_BYTES) begin
                    streaming       <= 1'b0;
                    flash_write_req <= 1'b1;
                end else begin
                    flash_wdata  <= page_mem[stream_idx[7:0]];
                    flash_wvalid <= 1'b1;
                    stream_idx   <= stream_idx + 9'h001;
                end
            end
        end
    end

    // primary status: ready bit and sticky error flags; failure wins over clear
    always_ff @(posedge ref_clk) begin
        if (!rst_n) begin
            primary_status <= `SFSP_STATUS_RESET;
        end else begin
            primary_status[`SFSP_BIT_READY] <= (state != SFSP_WRITE);
            if (state == SFSP_IDLE && rx_byte_valid && rx_byte == `SFSP_OP_CLEAR_STATUS) begin
                primary_status[`SFSP_BIT_PROG_ERR] <= 1'b0;
                primary_status[`SFSP_BIT_ERR_LOW]  <= 1'b0;
            end
            if (state == SFSP_WRITE && flash_done && flash_error) begin
                primary_status[`SFSP_BIT_PROG_ERR] <= 1'b1;
            end
        end
    end

    // busy from first bit of a byte until that byte ends, or until flash_done after the last page byte
    always_ff @(posedge ref_clk) begin
        if (!rst_n) begin
            handshake_pin <= 1'b0;
        end else if (clk_rise) begin
            handshake_pin <= 1'b1;
        end else if (rx_byte_valid) begin
            // low between bytes except while the page is being written
            handshake_pin <= page_last;
        end else if (state == SFSP_WRITE && flash_done) begin
            handshake_pin <= 1'b0;
        end
    end
endmodule

// file: sfsp_top_props.sv
`timescale 1ns/10ps
module sfsp_top_props (
    input wire logic        ref_clk,
    input wire logic        rst_n,
    input wire logic        serial_clock_in,
    input wire logic        serial_tx_line,
    input wire logic        handshake_pin,
    input wire logic [7:0]  primary_status,
    input wire logic        rx_byte_valid,
    input wire logic        flash_write_req,
    input wire logic [23:0] flash_addr,
    input wire logic        flash_wvalid,
    input wire logic        flash_done,
    input wire logic        flash_error
);
    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (!rst_n);
    logic [8:0] wcnt; // streamed bytes since the last write request
    // count streamed bytes; cleared by each write request so pages stay apart
    always_ff @(posedge ref_clk) begin
        if (!rst_n || flash_write_req) begin
            wcnt <= 9'h000;
        end else if (flash_wvalid) begin
            wcnt <= wcnt + 9'h001;
        end
    end
    // page write start, then busy must stay up for the next eight cycles
    sequence s_write_start; flash_write_req; endsequence
    sequence s_busy_hold; handshake_pin [*8]; endsequence
    page_count_a: assert property (flash_write_req |-> wcnt == 9'h100)
        else $error("page write after wrong byte count");
    low_addr_zero_a: assert property (flash_write_req |-> flash_addr[7:0] == 8'h00)
        else $error("page address low byte not zero");
    write_busy_hold_a: assert property (s_write_start |=> s_busy_hold)
        else $error("busy dropped during page write");
    stream_busy_a: assert property (flash_wvalid |-> handshake_pin)
        else $error("busy low while page streams");
    prog_err_set_a: assert property (flash_done & flash_error |-> ##[1:2] primary_status[4])
        else $error("program error flag not set");
    ready_back_a: assert property (flash_done |-> ##[1:2] primary_status[7])
        else $error("ready bit not restored");
    busy_release_a: assert property (flash_done |-> ##[1:4] !handshake_pin)
        else $error("busy not released after write");
    rx_strobe_a: assert property (rx_byte_valid |=> !rx_byte_valid [*8])
        else $error("byte strobe too long");
    busy_start_a: assert property ($rose(serial_clock_in) |-> ##[1:8] handshake_pin)
        else $error("busy not raised at byte start");
    idle_after_reset_a: assert property ($rose(rst_n) |-> serial_tx_line && !handshake_pin)
        else $error("outputs not idle after reset");
endmodule
bind sfsp_top sfsp_top_props u_props (.ref_clk, .rst_n, .serial_clock_in, .serial_tx_line,
    .handshake_pin, .primary_status, .rx_byte_valid, .flash_write_req, .flash_addr,
    .flash_wvalid, .flash_done, .flash_error);

// file: sfsp_prog_model.sv
`timescale 1ns/10ps
module sfsp_prog_model (
    input  wire logic ref_clk,         // system clock, keeps pin changes off its edges
    output logic      serial_clock_in, // transfer clock, stands high between frames
    output logic      serial_rx_line,  // data towards the device
    input  wire logic serial_tx_line,  // data from the device
    input  wire logic handshake_pin    // busy from the device
);
    int wait_ns; // bound on the busy wait so a stuck pin cannot hang us
    initial begin
        serial_clock_in = 1'b1;
        serial_rx_line  = 1'b1;
    end
    // one byte each way, lsb first; data moves while the clock is low
    task automatic xfer(input logic [7:0] out_byte, output logic [7:0] in_byte);
        // start 1 ns after a system edge; every later step keeps that offset
        @(posedge ref_clk);
        #1 wait_ns = 0;
        while (handshake_pin !== 1'b0 && wait_ns < 100000) begin
            #5 wait_ns += 5;
        end
        for (int i = 0; i < 8; i++) begin
            serial_clock_in = 1'b0;
            serial_rx_line  = out_byte[i];
            #40 serial_clock_in = 1'b1;
            in_byte[i] = serial_tx_line;
            #40;
        end
        serial_rx_line = ~out_byte[7]; // released line must not show a stale bit
    endtask
endmodule

// file: testbench.sv
`timescale 1ns/10ps
`include "sfsp_cfg.svh"
`define CHK(nm, ex, got) begin cmp_count++; if ((ex) !== (got)) begin err_count++; \
    $display("BAD %s exp %h got %h", nm, ex, got); end end
module testbench;
    typedef struct {logic [7:0] link; logic [7:0] prim;} sfsp_row_type;
    logic        ref_clk, rst_n, sclk, rxd, txd, busy, rx_byte_valid, flash_write_req;
    logic        flash_wvalid, flash_done, flash_error, fail_mode;
    logic [7:0]  link_status, primary_status, rx_byte, flash_wdata, p, l, d, mid_exp, hi_exp;
    logic [23:0] flash_addr;
    logic [8:0]  wcnt;      // bytes streamed to flash this page
    int          err_count, cmp_count;
    sfsp_row_type rows [3] = '{'{8'h00, 8'h80}, '{8'hFF, 8'h80}, '{8'h5A, 8'h80}};
    sfsp_top u_sfsp_top (.ref_clk, .rst_n, .serial_clock_in(sclk), .serial_rx_line(rxd),
        .serial_tx_line(txd), .handshake_pin(busy), .link_status, .primary_status,
        .rx_byte_valid, .rx_byte, .flash_write_req, .flash_addr, .flash_wdata,
        .flash_wvalid, .flash_done, .flash_error);
    sfsp_prog_model u_prog (.ref_clk, .serial_clock_in(sclk), .serial_rx_line(rxd),
        .serial_tx_line(txd), .handshake_pin(busy));
    initial begin
        ref_clk = 1'b0;
        forever #2.5 ref_clk = ~ref_clk;
    end
    // flash side: check the streamed bytes, then answer after a delay
    always @(posedge ref_clk) begin
        if (flash_wvalid === 1'b1) begin
            `CHK("wdata", wcnt[7:0] ^ 8'hA5, flash_wdata)
            wcnt++;
        end
        if (flash_write_req === 1'b1) begin
            `CHK("addr", {hi_exp, mid_exp, 8'h00}, flash_addr)
            `CHK("wcount", 9'h100, wcnt)
            wcnt = 9'h000;
            repeat (12) @(posedge ref_clk);
            `CHK("ready_low", 1'b0, primary_status[7])
            `CHK("busy_write", 1'b1, busy)
            flash_done  <= 1'b1;
            flash_error <= fail_mode;
            @(posedge ref_clk);
            flash_done  <= 1'b0;
            flash_error <= 1'b0;
        end
    end
    task automatic rd_status(output logic [7:0] ps, output logic [7:0] ls);
        u_prog.xfer(`SFSP_OP_READ_STATUS, d);
        u_prog.xfer(8'h00, ps);
        u_prog.xfer(8'h00, ls);
    endtask
    // whole page: opcode, middle and high address, then 256 bytes, each its index xor A5
    task automatic page(input logic [7:0] mid, input logic [7:0] hi);
        mid_exp = mid;
        hi_exp  = hi;
        u_prog.xfer(`SFSP_OP_PAGE_PROGRAM, d);
        u_prog.xfer(mid, d);
        u_prog.xfer(hi, d);
        for (int i = 0; i < 256; i++) u_prog.xfer(i[7:0] ^ 8'hA5, d);
    endtask
    task automatic results;
        $display("cmp_count %0d err_count %0d", cmp_count, err_count);
        if (err_count == 0 && cmp_count > 0) $display("Run complete: PASS");
        else $display("Run complete: FAIL");
        $finish;
    endtask
    // watchdog: about 540 bytes of 650 ns each, plus two page writes, with margin
    initial begin
        #450000 err_count++;
        results;
    end
    initial begin
        rst_n = 1'b0; link_status = 8'h00; flash_done = 1'b0; flash_error = 1'b0;
        fail_mode = 1'b1; wcnt = 9'h000; err_count = 0; cmp_count = 0;
        repeat (16) @(posedge ref_clk);
        rst_n <= 1'b1;
        // look a few settled cycles after release: a false clock edge would raise busy
        repeat (4) @(negedge ref_clk);
        `CHK("rst_status", `SFSP_STATUS_RESET, primary_status)
        `CHK("rst_busy", 1'b0, busy)
        `CHK("rst_tx", 1'b1, txd)
        repeat (4) @(posedge ref_clk);
        foreach (rows[i]) begin
            @(posedge ref_clk);
            link_status <= rows[i].link;
            rd_status(p, l);
            `CHK("primary", rows[i].prim, p)
            `CHK("link", rows[i].link, l)
        end
        page(8'h34, 8'h12); // failing write
        rd_status(p, l);
        `CHK("prog_err", 1'b1, p[4])
        `CHK("ready", 1'b1, p[7])
        u_prog.xfer(`SFSP_OP_CLEAR_STATUS, d);
        for (int k = 0; k < 400 && busy !== 1'b0; k++) @(posedge ref_clk);
        `CHK("clr_busy", 1'b0, busy)
        `CHK("rx_byte", `SFSP_OP_CLEAR_STATUS, rx_byte)
        rd_status(p, l);
        `CHK("cleared", 8'h80, p)
        fail_mode = 1'b0;
        page(8'hFF, 8'h00); // passing write at the top middle address
        rd_status(p, l);
        `CHK("prog_ok", 8'h80, p)
        results;
    end
endmodule
